// >>> logic/pft_pkg.sv
// Constants, codes and types for the program-flow trace item encoder.
// Assumes a single core clock; all users import the whole package.
package pft_pkg;

  // ==========================================================
  // Item layout
  localparam int ITEM_W = 18;
  localparam logic [17:0] ITEM_RST = 18'h00000;
  localparam logic [1:0] TAG_BRANCH = 2'h0;
  localparam logic [1:0] TAG_PC = 2'h1;
  localparam logic [1:0] TAG_DATA = 2'h2;
  localparam logic [1:0] TAG_EVENT = 2'h3;

  // ==========================================================
  // Event subtypes and exception causes
  localparam logic [1:0] EV_SOFT = 2'h0;
  localparam logic [1:0] EV_TSTAMP = 2'h1;
  localparam logic [1:0] EV_XTRIG = 2'h2;
  localparam logic [1:0] EV_EXC = 2'h3;
  localparam logic [4:0] EXC_DEBUG = 5'h09;
  localparam logic [4:0] EXC_IRQ = 5'h0a;
  localparam logic [4:0] EXC_NMBRK = 5'h0b;
  localparam logic [4:0] EXC_BRK = 5'h0c;

  // ==========================================================
  // Branch items
  localparam logic [3:0] BR_MAX = 4'hc;
  localparam logic [1:0] BR_ONE = 2'h1;
  localparam logic [1:0] BR_TWO = 2'h2;
  localparam logic [1:0] BR_LONG = 2'h3;
  localparam logic [12:0] SHORT_MAX = 13'h003f;
  localparam logic [12:0] CYC_SAT = 13'h1fff;
  localparam logic [13:0] TS_SAT = 14'h3fff;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    PFT_PC = 3'h0,
    PFT_LOAD = 3'h1,
    PFT_LLOAD = 3'h2,
    PFT_SOFT = 3'h3,
    PFT_XTRIG = 3'h4,
    PFT_EXC = 3'h5,
    PFT_TSTAMP = 3'h6
  } pft_kind_type;

  typedef enum logic [1:0] {
    PFT_ST_IDLE = 2'b01,
    PFT_ST_SEND = 2'b10
  } pft_state_type;

endpackage

// >>> logic/pft_branch_packer.sv
// Packs branch outcomes into plain, short or long branch items.
// Assumes same-clock core strobes and a consumer that pulses take_i.
`timescale 1ns/100ps
module pft_branch_packer
  import pft_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic cycle_mode_i,
  input wire logic branch_valid_i,
  input wire logic branch_taken_i,
  output logic branch_ready_o,
  input wire logic flush_i,
  input wire logic take_i,
  output logic item_valid_o,
  output logic [17:0] item_data_o,
  output logic pending_o
);

  // ==========================================================
  // State
  logic [3:0] n_reg, n_next;
  logic [11:0] bits_reg, bits_next;
  logic [6:0] c1_reg, c1_next;
  logic [12:0] cyc_reg, cyc_next;
  logic vld_reg, vld_next;
  logic [17:0] item_reg, item_next;
  logic long_need, acc;

  assign long_need = cycle_mode_i && (cyc_reg > SHORT_MAX);
  assign branch_ready_o = !vld_reg && !(long_need && (n_reg != 4'h0));
  assign acc = branch_valid_i && branch_ready_o;
  assign item_valid_o = vld_reg;
  assign item_data_o = item_reg;
  assign pending_o = vld_reg || (n_reg != 4'h0);

  always_comb begin
    n_next = n_reg;
    bits_next = bits_reg;
    c1_next = c1_reg;
    item_next = item_reg;
    vld_next = vld_reg && !take_i;
    cyc_next = (cyc_reg == CYC_SAT) ? cyc_reg : cyc_reg + 13'h0001;
    if (acc) begin
      cyc_next = 13'h0000;
      if (!cycle_mode_i) begin
        bits_next[4'hb - n_reg] = branch_taken_i;
        n_next = n_reg + 4'h1;
        if (n_reg + 4'h1 == BR_MAX) begin
          item_next = {TAG_BRANCH, BR_MAX, bits_next};
          vld_next = 1'b1;
          n_next = 4'h0;
        end
      end else if (long_need) begin
        item_next = {TAG_BRANCH, BR_LONG, cyc_reg, branch_taken_i};
        vld_next = 1'b1;
      end else if (n_reg == 4'h0) begin
        c1_next = {cyc_reg[5:0], branch_taken_i};
        n_next = 4'h1;
      end else begin
        item_next = {TAG_BRANCH, BR_TWO, c1_reg, cyc_reg[5:0], branch_taken_i};
        vld_next = 1'b1;
        n_next = 4'h0;
      end
    end else if (!vld_reg && (n_reg != 4'h0) && (flush_i || long_need)) begin
      if (cycle_mode_i) begin
        item_next = {TAG_BRANCH, BR_ONE, c1_reg, 7'h00};
      end else begin
        item_next = {TAG_BRANCH, n_reg, bits_reg};
      end
      vld_next = 1'b1;
      n_next = 4'h0;
      bits_next = 12'h000;
    end
    if (vld_next && !vld_reg && !cycle_mode_i && (n_next == 4'h0)) begin
      bits_next = 12'h000;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      n_reg <= 4'h0;
      bits_reg <= 12'h000;
      c1_reg <= 7'h00;
      cyc_reg <= 13'h0000;
      vld_reg <= 1'b0;
      item_reg <= ITEM_RST;
    end else begin
      n_reg <= n_next;
      bits_reg <= bits_next;
      c1_reg <= c1_next;
      cyc_reg <= cyc_next;
      vld_reg <= vld_next;
      item_reg <= item_next;
    end
  end

  // ==========================================================
  // Checks
  a_short_form: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (acc && cycle_mode_i && !long_need && n_reg == 4'h1) |=>
      (vld_reg && item_reg[17:14] == {TAG_BRANCH, BR_TWO} && item_reg[0] == $past(branch_taken_i)))
    else $error("short branch item malformed");
  a_long_choice: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (acc && cycle_mode_i && cyc_reg > SHORT_MAX) |=>
      (item_reg[15:14] == BR_LONG && item_reg[13:1] == $past(cyc_reg)))
    else $error("long branch item not chosen");

endmodule

// >>> logic/pft_item_encoder.sv
// Program-flow trace item encoder: turns core trace requests into 18-bit items.
// Assumes core-side strobes on ref_clk_i and a trace buffer that accepts via ready.
`timescale 1ns/100ps

// Behaviour
// - Items are 18 bits, delivered oldest first; entities may span several items.
// - Plain branch item: tag 00, count 0-12, outcomes left-aligned, 1 is taken.
// - Address width 32-48: PC sent as three tag-01 items, top bits zero-extended.
// - Address width 49-64: PC sent as four tag-01 items, most significant first.
// - Ordinary load data: two tag-10 items, upper 16 bits first.
// - Data width 64: long load data as four tag-10 items, most significant first.
// - Every event item has tag 11 and a 2-bit subtype in bits 15:14.
// - Software event: subtype 00, bits 13:0 hold the instruction result.
// - Cross-trigger event: subtype 10, one bit per event in 7:0, 13:8 zero.
// - Exception event: subtype 11, cause in 4:0, bits 13:5 zero.
// - Time stamp: subtype 01, bits 13:0 count cycles since previous stamp.
// - Cycle mode short item: 01 or 10 branches, 6-bit count then taken bit each.
// - Cycle mode long item: subtype 11, 13-bit count in 13:1, taken in bit 0.
module pft_item_encoder
  import pft_pkg::*;
#(
  parameter int ADDR_WIDTH = 32,
  parameter int DATA_WIDTH = 32
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic cycle_mode_i,
  input wire logic branch_valid_i,
  input wire logic branch_taken_i,
  output logic branch_ready_o,
  input wire logic req_valid_i,
  input wire pft_kind_type req_kind_i,
  input wire logic [63:0] req_data_i,
  output logic req_ready_o,
  output logic item_valid_o,
  output logic [17:0] item_data_o,
  input wire logic item_ready_i
);

  localparam logic [63:0] ADDR_MASK = {64{1'b1}} >> (64 - ADDR_WIDTH);

  // ==========================================================
  // Branch packer
  logic pk_valid, pk_pend, pk_take;
  logic [17:0] pk_data;

  pft_branch_packer u_packer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .cycle_mode_i(cycle_mode_i),
    .branch_valid_i(branch_valid_i),
    .branch_taken_i(branch_taken_i),
    .branch_ready_o(branch_ready_o),
    .flush_i(req_valid_i),
    .take_i(pk_take),
    .item_valid_o(pk_valid),
    .item_data_o(pk_data),
    .pending_o(pk_pend)
  );

  // ==========================================================
  // Entity build
  pft_state_type state_reg, state_next;
  logic [17:0] ent_reg [0:2];
  logic [17:0] ent_next [0:2];
  logic [1:0] rem_reg, rem_next;
  logic out_vld_reg, out_vld_next;
  logic [17:0] out_data_reg, out_data_next;
  logic [13:0] ts_cnt_reg, ts_cnt_next;
  logic [17:0] ent_w [0:3];
  logic [2:0] ent_len;
  logic [63:0] pc_m;
  logic out_free, accept;

  assign pc_m = req_data_i & ADDR_MASK;
  assign out_free = !out_vld_reg || item_ready_i;
  assign req_ready_o = (state_reg == PFT_ST_IDLE) && !pk_pend && out_free;
  assign accept = req_valid_i && req_ready_o;
  assign pk_take = (state_reg == PFT_ST_IDLE) && pk_valid && out_free;
  assign item_valid_o = out_vld_reg;
  assign item_data_o = out_data_reg;

  always_comb begin
    ent_w[0] = ITEM_RST;
    ent_w[1] = ITEM_RST;
    ent_w[2] = ITEM_RST;
    ent_w[3] = ITEM_RST;
    ent_len = 3'h1;
    unique case (req_kind_i)
      PFT_PC: begin
        if (ADDR_WIDTH > 48) begin
          ent_w[0] = {TAG_PC, pc_m[63:48]};
          ent_w[1] = {TAG_PC, pc_m[47:32]};
          ent_w[2] = {TAG_PC, pc_m[31:16]};
          ent_w[3] = {TAG_PC, pc_m[15:0]};
          ent_len = 3'h4;
        end else begin
          ent_w[0] = {TAG_PC, pc_m[47:32]};
          ent_w[1] = {TAG_PC, pc_m[31:16]};
          ent_w[2] = {TAG_PC, pc_m[15:0]};
          ent_len = 3'h3;
        end
      end
      PFT_LOAD, PFT_LLOAD: begin
        if (req_kind_i == PFT_LLOAD && DATA_WIDTH == 64) begin
          ent_w[0] = {TAG_DATA, req_data_i[63:48]};
          ent_w[1] = {TAG_DATA, req_data_i[47:32]};
          ent_w[2] = {TAG_DATA, req_data_i[31:16]};
          ent_w[3] = {TAG_DATA, req_data_i[15:0]};
          ent_len = 3'h4;
        end else begin
          ent_w[0] = {TAG_DATA, req_data_i[31:16]};
          ent_w[1] = {TAG_DATA, req_data_i[15:0]};
          ent_len = 3'h2;
        end
      end
      PFT_SOFT: ent_w[0] = {TAG_EVENT, EV_SOFT, req_data_i[13:0]};
      PFT_XTRIG: ent_w[0] = {TAG_EVENT, EV_XTRIG, 6'h00, req_data_i[7:0]};
      PFT_EXC: ent_w[0] = {TAG_EVENT, EV_EXC, 9'h000, req_data_i[4:0]};
      PFT_TSTAMP: ent_w[0] = {TAG_EVENT, EV_TSTAMP, ts_cnt_reg};
      default: ent_w[0] = {TAG_EVENT, EV_SOFT, 14'h0000};
    endcase
  end

  // ==========================================================
  // Output sequencing
  always_comb begin
    state_next = state_reg;
    rem_next = rem_reg;
    ent_next[0] = ent_reg[0];
    ent_next[1] = ent_reg[1];
    ent_next[2] = ent_reg[2];
    out_data_next = out_data_reg;
    out_vld_next = out_vld_reg && !item_ready_i;
    ts_cnt_next = (ts_cnt_reg == TS_SAT) ? ts_cnt_reg : ts_cnt_reg + 14'h0001;
    unique case (state_reg)
      PFT_ST_IDLE: begin
        if (accept) begin
          out_data_next = ent_w[0];
          out_vld_next = 1'b1;
          ent_next[0] = ent_w[1];
          ent_next[1] = ent_w[2];
          ent_next[2] = ent_w[3];
          rem_next = 2'(ent_len - 3'h1);
          if (ent_len != 3'h1) begin
            state_next = PFT_ST_SEND;
          end
          if (req_kind_i == PFT_TSTAMP) begin
            ts_cnt_next = 14'h0001;
          end
        end else if (pk_take) begin
          out_data_next = pk_data;
          out_vld_next = 1'b1;
        end
      end
      PFT_ST_SEND: begin
        if (out_free) begin
          out_data_next = ent_reg[0];
          out_vld_next = 1'b1;
          ent_next[0] = ent_reg[1];
          ent_next[1] = ent_reg[2];
          rem_next = rem_reg - 2'h1;
          if (rem_reg == 2'h1) begin
            state_next = PFT_ST_IDLE;
          end
        end
      end
      default: state_next = PFT_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= PFT_ST_IDLE;
      rem_reg <= 2'h0;
      ent_reg[0] <= ITEM_RST;
      ent_reg[1] <= ITEM_RST;
      ent_reg[2] <= ITEM_RST;
      out_vld_reg <= 1'b0;
      out_data_reg <= ITEM_RST;
      ts_cnt_reg <= 14'h0000;
    end else begin
      state_reg <= state_next;
      rem_reg <= rem_next;
      ent_reg[0] <= ent_next[0];
      ent_reg[1] <= ent_next[1];
      ent_reg[2] <= ent_next[2];
      out_vld_reg <= out_vld_next;
      out_data_reg <= out_data_next;
      ts_cnt_reg <= ts_cnt_next;
    end
  end

  // ==========================================================
  // Checks
  a_out_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (item_valid_o && !item_ready_i) |=> (item_valid_o && $stable(item_data_o)))
    else $error("item changed before it was taken");
  a_branch_count: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (pk_take && !cycle_mode_i) |=> (item_data_o[17:16] == TAG_BRANCH && item_data_o[15:12] <= BR_MAX))
    else $error("plain branch item malformed");
  a_pc_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (accept && req_kind_i == PFT_PC) |=>
      (item_data_o[17:16] == TAG_PC && rem_reg == ((ADDR_WIDTH > 48) ? 2'h3 : 2'h2)))
    else $error("program counter entity malformed");
  a_load_order: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (accept && req_kind_i == PFT_LOAD) |=>
      (item_data_o == {TAG_DATA, $past(req_data_i[31:16])} && ent_reg[0][15:0] == $past(req_data_i[15:0])))
    else $error("load data items out of order");
  a_soft_event: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (accept && req_kind_i == PFT_SOFT) |=>
      (item_data_o == {TAG_EVENT, EV_SOFT, $past(req_data_i[13:0])}))
    else $error("software event item malformed");
  a_xtrig_resv: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (accept && req_kind_i == PFT_XTRIG) |=>
      (item_data_o[15:14] == EV_XTRIG && item_data_o[13:8] == 6'h00))
    else $error("cross-trigger item malformed");
  a_exc_resv: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (accept && req_kind_i == PFT_EXC) |=>
      (item_data_o[17:14] == {TAG_EVENT, EV_EXC} && item_data_o[13:5] == 9'h000))
    else $error("exception item malformed");
  a_tstamp_cnt: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (accept && req_kind_i == PFT_TSTAMP) |=>
      (item_data_o[13:0] == $past(ts_cnt_reg) && ts_cnt_reg == 14'h0001))
    else $error("time stamp count wrong");
  a_entity_contig: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_reg == PFT_ST_SEND) |-> (!pk_take && !req_ready_o) ##1
      (item_valid_o && item_data_o[17:16] == $past(item_data_o[17:16])))
    else $error("entity interleaved with other items");

endmodule

// >>> sim/pft_trace_buffer.sv
// Trace buffer model: stores accepted items in arrival order.
// Assumes the encoder holds item_valid_i and item_data_i until accepted.
`timescale 1ns/100ps
module pft_trace_buffer (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic item_valid_i,
  input wire logic [17:0] item_data_i,
  output logic item_ready_o
);
  logic [17:0] got [$];
  // ==========
  // Accept, store oldest first, stall every other cycle when slow
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      item_ready_o <= 1'b0;
    end else begin
      if (item_valid_i && item_ready_o) begin
        got.push_back(item_data_i);
      end
      item_ready_o <= slow_i ? ~item_ready_o : 1'b1;
    end
  end
endmodule

// >>> sim/tb_pft_item_encoder.sv
// Testbench for the trace item encoder: request table, branch and stamp cases.
// Assumes the buffer model in pft_trace_buffer and a 56-bit address, 64-bit data build.
`timescale 1ns/100ps
module tb_pft_item_encoder;
  import pft_pkg::*;
  typedef struct {
    pft_kind_type kind;
    logic [63:0] data;
    int n;
    logic [17:0] exp [4];
  } pft_row_type;
  logic ref_clk_i, reset_i, cycle_mode_i, branch_valid_i, branch_taken_i, branch_ready_o;
  logic req_valid_i, req_ready_o, item_valid_o, item_ready_i, slow;
  pft_kind_type req_kind_i;
  logic [63:0] req_data_i;
  logic [17:0] item_data_o;
  logic [11:0] pat;
  logic [4:0] cause [4];
  pft_row_type rows [9];
  int mismatches, total_checks, r, j;
  longint t0, t1, ta, tb1, tc, td, te;

  pft_item_encoder #(.ADDR_WIDTH(56), .DATA_WIDTH(64)) u_dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .cycle_mode_i(cycle_mode_i), .branch_valid_i(branch_valid_i),
    .branch_taken_i(branch_taken_i), .branch_ready_o(branch_ready_o),
    .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_data_i(req_data_i),
    .req_ready_o(req_ready_o), .item_valid_o(item_valid_o), .item_data_o(item_data_o),
    .item_ready_i(item_ready_i));
  pft_trace_buffer u_buf (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .slow_i(slow),
    .item_valid_i(item_valid_o), .item_data_i(item_data_o), .item_ready_o(item_ready_i));

  // ==========
  // Compare, closing, drive and wait tasks
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic timeout(input string what);
    mismatches++;
    $display("timeout waiting for %s", what);
    end_sim();
  endtask
  task automatic send(input pft_kind_type k, input logic [63:0] d, output longint t);
    int i;
    @(negedge ref_clk_i);
    req_valid_i = 1'b1;
    req_kind_i = k;
    req_data_i = d;
    for (i = 0; i < 500; i++) begin
      @(posedge ref_clk_i);
      if (req_ready_o === 1'b1) break;
    end
    if (i == 500) timeout("request");
    t = $time / 50;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
  endtask
  task automatic br(input logic tk, output longint t);
    int i;
    @(negedge ref_clk_i);
    branch_valid_i = 1'b1;
    branch_taken_i = tk;
    for (i = 0; i < 500; i++) begin
      @(posedge ref_clk_i);
      if (branch_ready_o === 1'b1) break;
    end
    if (i == 500) timeout("branch");
    t = $time / 50;
  endtask
  task automatic idle(input int n);
    @(negedge ref_clk_i);
    branch_valid_i = 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wait_items(input int n);
    int i;
    for (i = 0; i < 500 && u_buf.got.size() < n; i++) @(posedge ref_clk_i);
    if (i == 500) timeout("items");
  endtask

  // ==========
  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ==========
  // Main sequence
  initial begin
    {reset_i, cycle_mode_i, branch_valid_i, branch_taken_i, req_valid_i, slow} = 6'h20;
    req_kind_i = PFT_PC;
    req_data_i = 64'h0;
    rows[0] = '{PFT_PC, 64'hfedc_ba98_7654_3210, 4, '{18'h100dc, 18'h1ba98, 18'h17654, 18'h13210}};
    rows[1] = '{PFT_LOAD, 64'hffff_ffff_a5c3_1e2f, 2, '{18'h2a5c3, 18'h21e2f, 18'h0, 18'h0}};
    rows[2] = '{PFT_LLOAD, 64'h1234_5678_9abc_def0, 4, '{18'h21234, 18'h25678, 18'h29abc, 18'h2def0}};
    rows[3] = '{PFT_SOFT, 64'hffff_ffff_ffff_ea5b, 1, '{18'h32a5b, 18'h0, 18'h0, 18'h0}};
    rows[4] = '{PFT_XTRIG, 64'hffff_ffff_ffff_ffa5, 1, '{18'h380a5, 18'h0, 18'h0, 18'h0}};
    cause = '{5'h09, 5'h0a, 5'h0b, 5'h0c};
    for (j = 0; j < 4; j++) begin
      rows[5 + j] = '{PFT_EXC, {{59{1'b1}}, cause[j]}, 1, '{{4'hf, 9'h0, cause[j]}, 18'h0, 18'h0, 18'h0}};
    end
    repeat (6) @(posedge ref_clk_i);
    check("item_valid_o", 18'h0, {17'h0, item_valid_o});
    check("item_data_o", 18'h0, item_data_o);
    check("req_ready_o", 18'h1, {17'h0, req_ready_o});
    check("branch_ready_o", 18'h1, {17'h0, branch_ready_o});
    @(negedge ref_clk_i);
    reset_i = 1'b0;
    $display("test reset done");
    for (r = 0; r < 9; r++) begin
      @(negedge ref_clk_i);
      slow = r[0];
      u_buf.got.delete();
      send(rows[r].kind, rows[r].data, t0);
      wait_items(rows[r].n);
      repeat (4) @(posedge ref_clk_i);
      check("item count", 18'(rows[r].n), 18'(u_buf.got.size()));
      for (j = 0; j < rows[r].n; j++) begin
        check("item", rows[r].exp[j], u_buf.got[j]);
      end
      $display("test row %0d done", r);
    end
    slow = 1'b0;
    u_buf.got.delete();
    pat = 12'hb2d;
    for (j = 11; j >= 0; j--) br(pat[j], t0);
    br(1'b1, t0);
    br(1'b0, t0);
    br(1'b1, t0);
    idle(2);
    send(PFT_XTRIG, 64'h0000_0000_0000_ffa5, t0);
    wait_items(3);
    check("plain full", 18'h0cb2d, u_buf.got[0]);
    check("plain flush", 18'h03a00, u_buf.got[1]);
    check("flush order", 18'h380a5, u_buf.got[2]);
    $display("test plain branches done");
    @(negedge ref_clk_i);
    cycle_mode_i = 1'b1;
    u_buf.got.delete();
    repeat (70) @(posedge ref_clk_i);
    br(1'b1, ta);
    idle(3);
    br(1'b0, tb1);
    idle(2);
    br(1'b1, tc);
    idle(80);
    br(1'b0, td);
    idle(4);
    br(1'b1, te);
    idle(2);
    send(PFT_SOFT, 64'h0, t0);
    wait_items(5);
    check("long first", 18'h0c001, u_buf.got[0] & 18'h3c001);
    check("short pair", {4'h2, 6'(tb1 - ta - 1), 1'b0, 6'(tc - tb1 - 1), 1'b1}, u_buf.got[1]);
    check("long gap", {4'h3, 13'(td - tc - 1), 1'b0}, u_buf.got[2]);
    check("short lone", {4'h1, 6'(te - td - 1), 1'b1, 7'h0}, u_buf.got[3]);
    check("soft after", 18'h30000, u_buf.got[4]);
    $display("test cycle branches done");
    u_buf.got.delete();
    send(PFT_TSTAMP, 64'h0, t0);
    repeat (20) @(posedge ref_clk_i);
    send(PFT_TSTAMP, 64'h0, t1);
    wait_items(2);
    check("stamp", {4'hd, 14'(t1 - t0)}, u_buf.got[1]);
    $display("test stamp done");
    end_sim();
  end
endmodule
